// ### core/pbs_map.svh
`ifndef PBS_MAP_SVH
`define PBS_MAP_SVH
`define PBS_ADDR_W        17
`define PBS_DATA_W        36
`define PBS_BW_W          4
`define PBS_BYTE_W        9
`define PBS_DEPTH         131072
`define PBS_BURST_LEN     3'h4
`define PBS_PIPE_DEPTH    2
`define PBS_ORDER_RESET   1'b1
`endif

// ### core/pbs_pkg.sv
`include "pbs_map.svh"
package pbs_pkg;
    typedef logic [`PBS_ADDR_W-1:0] pbs_addr_t;
    typedef logic [`PBS_DATA_W-1:0] pbs_data_t;
    typedef logic [`PBS_BW_W-1:0]   pbs_bw_t;
    typedef enum logic [1:0] {
        PBS_IDLE  = 2'h0,
        PBS_READ  = 2'h1,
        PBS_WRITE = 2'h3
    } pbs_op_e;
    typedef struct packed {
        logic      valid;
        logic      write;
        pbs_addr_t addr;
        pbs_bw_t   bw_n;
    } pbs_stage_s;
    function automatic logic [1:0] pbs_burst_low(input logic [1:0] base,
                                                 input logic [1:0] count,
                                                 input logic       linear);
        pbs_burst_low = linear ? 2'(base + count) : (base ^ count);
    endfunction
endpackage

// ### core/pbs_bus_if.sv
`timescale 1ns/1ps
`include "pbs_map.svh"
interface pbs_bus_if;
    logic               clock_hold_n;
    logic               advance_or_load;
    logic               rw;
    logic               chip_select_first_n;
    logic               chip_select_second_n;
    logic               chip_select_second;
    logic               burst_order_select;
    logic               burst_order_select_oe;
    pbs_pkg::pbs_addr_t addr;
    pbs_pkg::pbs_bw_t   byte_write_select_n;
    pbs_pkg::pbs_data_t dq_host_o;
    logic               dq_host_oe;
    pbs_pkg::pbs_data_t dq_dev_o;
    logic               dq_dev_oe;
    pbs_pkg::pbs_data_t dq;
    logic               order_level;
    // resolved bus: host drive wins visibly only when device is off
    assign dq          = dq_dev_oe ? dq_dev_o : (dq_host_oe ? dq_host_o : '0);
    assign order_level = burst_order_select_oe ? burst_order_select : `PBS_ORDER_RESET;
    modport dev (
        input  clock_hold_n, advance_or_load, rw, chip_select_first_n,
        input  chip_select_second_n, chip_select_second, order_level, addr,
        input  byte_write_select_n, dq,
        output dq_dev_o, dq_dev_oe
    );
    modport host (
        output clock_hold_n, advance_or_load, rw, chip_select_first_n,
        output chip_select_second_n, chip_select_second, burst_order_select,
        output burst_order_select_oe, addr, byte_write_select_n,
        output dq_host_o, dq_host_oe,
        input  dq
    );
endinterface

// ### core/pbs_sram_dev.sv
`timescale 1ns/1ps
`include "pbs_map.svh"
module pbs_sram_dev (
    input  wire logic clk,
    input  wire logic rst_n,
    pbs_bus_if.dev    bus
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic                 active;
        logic                 write;
        pbs_pkg::pbs_addr_t   base;
        logic [1:0]           count;
        pbs_pkg::pbs_stage_s  st1;
        pbs_pkg::pbs_stage_s  st2;
        pbs_pkg::pbs_data_t   dout;
        logic                 doe;
    } pbs_dev_s;

    // ----------------------------------------
    // signals
    // ----------------------------------------
    pbs_dev_s            s_reg;
    pbs_dev_s            s_next;
    pbs_pkg::pbs_data_t  mem [`PBS_DEPTH];
    pbs_pkg::pbs_stage_s now_st;
    pbs_pkg::pbs_op_e    cmd;
    logic                selected;
    logic                burst_more;
    pbs_pkg::pbs_data_t  rd_word;

    // ----------------------------------------
    // select decode
    // ----------------------------------------
    function automatic logic pbs_dev_sel(input logic first_n,
                                         input logic second_n,
                                         input logic second);
        pbs_dev_sel = ~first_n & ~second_n & second;
    endfunction

    // ----------------------------------------
    // command decode at a load edge
    // ----------------------------------------
    function automatic pbs_pkg::pbs_op_e pbs_dev_cmd(input logic sel,
                                                     input logic rw);
        if (!sel) begin
            pbs_dev_cmd = pbs_pkg::PBS_IDLE;
        end else if (rw) begin
            pbs_dev_cmd = pbs_pkg::PBS_READ;
        end else begin
            pbs_dev_cmd = pbs_pkg::PBS_WRITE;
        end
    endfunction

    // ----------------------------------------
    // burst counter step
    // ----------------------------------------
    function automatic logic [1:0] pbs_dev_step(input logic [1:0] count);
        pbs_dev_step = 2'(count + 2'h1);
    endfunction

    // ----------------------------------------
    // last word of a burst
    // ----------------------------------------
    function automatic logic pbs_dev_last(input logic [1:0] count);
        pbs_dev_last = ({1'b0, count} == 3'(`PBS_BURST_LEN - 3'h1));
    endfunction

    // ----------------------------------------
    // burst word address
    // ----------------------------------------
    function automatic pbs_pkg::pbs_addr_t pbs_dev_word(input pbs_pkg::pbs_addr_t base,
                                                        input logic [1:0]         count,
                                                        input logic               linear);
        pbs_dev_word = {base[`PBS_ADDR_W-1:2],
                        pbs_pkg::pbs_burst_low(base[1:0], count, linear)};
    endfunction

    // ----------------------------------------
    // one pipeline stage
    // ----------------------------------------
    function automatic pbs_pkg::pbs_stage_s pbs_dev_stage(input logic               valid,
                                                          input logic               write,
                                                          input pbs_pkg::pbs_addr_t addr,
                                                          input pbs_pkg::pbs_bw_t   bw_n);
        pbs_dev_stage       = '0;
        pbs_dev_stage.valid = valid;
        pbs_dev_stage.write = write;
        pbs_dev_stage.addr  = addr;
        pbs_dev_stage.bw_n  = bw_n;
    endfunction

    // ----------------------------------------
    // read stage
    // ----------------------------------------
    function automatic logic pbs_dev_is_read(input pbs_pkg::pbs_stage_s st);
        pbs_dev_is_read = st.valid & ~st.write;
    endfunction

    // ----------------------------------------
    // write stage
    // ----------------------------------------
    function automatic logic pbs_dev_is_write(input pbs_pkg::pbs_stage_s st);
        pbs_dev_is_write = st.valid & st.write;
    endfunction

    // ----------------------------------------
    // byte lane merge
    // ----------------------------------------
    function automatic pbs_pkg::pbs_data_t pbs_dev_merge(input pbs_pkg::pbs_data_t old_word,
                                                         input pbs_pkg::pbs_data_t new_word,
                                                         input pbs_pkg::pbs_bw_t   bw_n);
        pbs_dev_merge = old_word;
        for (int b = 0; b < `PBS_BW_W; b++) begin
            if (!bw_n[b]) begin
                pbs_dev_merge[b*`PBS_BYTE_W +: `PBS_BYTE_W] =
                    new_word[b*`PBS_BYTE_W +: `PBS_BYTE_W];
            end
        end
    endfunction

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        s_next     = s_reg;
        selected   = pbs_dev_sel(bus.chip_select_first_n,
                                 bus.chip_select_second_n,
                                 bus.chip_select_second);
        cmd        = pbs_dev_cmd(selected, bus.rw);
        burst_more = s_reg.active && !pbs_dev_last(s_reg.count);
        now_st     = '0;
        rd_word    = mem[s_reg.st2.addr];
        if (!bus.clock_hold_n) begin
            if (!bus.advance_or_load) begin
                case (cmd)
                    pbs_pkg::PBS_READ, pbs_pkg::PBS_WRITE: begin
                        s_next.active = 1'b1;
                        s_next.write  = (cmd == pbs_pkg::PBS_WRITE);
                        s_next.base   = bus.addr;
                        s_next.count  = 2'h0;
                        now_st        = pbs_dev_stage(1'b1, s_next.write, bus.addr,
                                                      bus.byte_write_select_n);
                    end
                    default: begin
                        s_next.active = 1'b0;
                        s_next.count  = 2'h0;
                    end
                endcase
            end else if (burst_more) begin
                s_next.count = pbs_dev_step(s_reg.count);
                now_st       = pbs_dev_stage(1'b1, s_reg.write,
                                             pbs_dev_word(s_reg.base, s_next.count,
                                                          bus.order_level),
                                             bus.byte_write_select_n);
            end
            s_next.st1 = now_st;
            s_next.st2 = s_reg.st1;
            s_next.doe = pbs_dev_is_read(s_reg.st2);
            if (pbs_dev_is_read(s_reg.st2)) begin
                s_next.dout = rd_word;
            end
        end
    end

    // ----------------------------------------
    // state registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------
    // memory array
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst_n && !bus.clock_hold_n && pbs_dev_is_write(s_reg.st2)) begin
            mem[s_reg.st2.addr] <= pbs_dev_merge(mem[s_reg.st2.addr], bus.dq,
                                                 s_reg.st2.bw_n);
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign bus.dq_dev_o  = s_reg.dout;
    assign bus.dq_dev_oe = s_reg.doe;
endmodule

// ### core/pbs_sram_host.sv
`timescale 1ns/1ps
`include "pbs_map.svh"
module pbs_sram_host (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               req_valid,
    output logic                    req_ready,
    input  wire logic               req_write,
    input  wire logic               req_burst,
    input  wire logic               req_linear,
    input  wire logic               hold,
    input  wire pbs_pkg::pbs_addr_t req_addr,
    input  wire pbs_pkg::pbs_bw_t   req_bw_n,
    input  wire pbs_pkg::pbs_data_t wr_data,
    output pbs_pkg::pbs_data_t      rd_data,
    output logic                    rd_valid,
    pbs_bus_if.host                 bus
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [1:0]         left;
        logic               write;
        logic [1:0]         wpipe;
        logic [2:0]         rpipe;
        pbs_pkg::pbs_data_t wd1;
        pbs_pkg::pbs_data_t wd2;
        pbs_pkg::pbs_data_t rdat;
        logic               rval;
    } pbs_host_s;

    pbs_host_s s_reg;
    pbs_host_s s_next;
    logic      issue;
    logic      adv;

    always_comb begin
        s_next    = s_reg;
        req_ready = ~hold & (s_reg.left == 2'h0);
        issue     = req_valid & req_ready;
        adv       = ~hold & (s_reg.left != 2'h0);
        s_next.rval = 1'b0;
        if (!hold) begin
            if (issue) begin
                s_next.left  = req_burst ? 2'h3 : 2'h0;
                s_next.write = req_write;
            end else if (adv) begin
                s_next.left  = 2'(s_reg.left - 2'h1);
            end
            s_next.wpipe = {s_reg.wpipe[0], (issue & req_write) | (adv & s_reg.write)};
            s_next.rpipe = {s_reg.rpipe[1:0], (issue & ~req_write) | (adv & ~s_reg.write)};
            s_next.wd1   = wr_data;
            s_next.wd2   = s_reg.wd1;
            s_next.rval  = s_reg.rpipe[2];
            s_next.rdat  = bus.dq;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign bus.clock_hold_n          = hold;
    assign bus.advance_or_load       = adv;
    assign bus.rw                    = ~req_write;
    assign bus.chip_select_first_n   = ~issue;
    assign bus.chip_select_second_n  = ~issue;
    assign bus.chip_select_second    = issue;
    assign bus.burst_order_select    = req_linear;
    assign bus.burst_order_select_oe = ~req_linear;
    assign bus.addr                  = req_addr;
    assign bus.byte_write_select_n   = req_bw_n;
    assign bus.dq_host_o             = s_reg.wd2;
    assign bus.dq_host_oe            = s_reg.wpipe[1];
    assign rd_data                   = s_reg.rdat;
    assign rd_valid                  = s_reg.rval;
endmodule

// ### testbench/pbs_bus_assertions.sv
`timescale 1ns/1ps
module pbs_bus_assertions (
    input logic               clk,
    input logic               rst_n,
    input logic               clock_hold_n,
    input logic               advance_or_load,
    input logic               rw,
    input logic               chip_select_first_n,
    input logic               chip_select_second_n,
    input logic               chip_select_second,
    input logic               dq_dev_oe,
    input pbs_pkg::pbs_data_t dq_dev_o
);
    // ------------------------------------------------
    // bus timing checks
    // ------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic run;
    logic ld;
    assign run = !clock_hold_n;
    assign ld  = run && !advance_or_load && !chip_select_first_n && !chip_select_second_n
                 && chip_select_second;
    property p_rd_lat; ld && rw ##1 run [*2] |=> dq_dev_oe; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read data late");
    property p_wr_quiet; ld && !rw ##1 run [*2] |=> !dq_dev_oe; endproperty
    a_wr_quiet: assert property (p_wr_quiet) else $error("bus driven on write");
    property p_burst_rd; ld && rw ##1 (run && advance_or_load) [*3] |=> dq_dev_oe; endproperty
    a_burst_rd: assert property (p_burst_rd) else $error("read burst lost");
    property p_burst_wr; ld && !rw ##1 (run && advance_or_load) [*3] |=> !dq_dev_oe; endproperty
    a_burst_wr: assert property (p_burst_wr) else $error("write burst read");
    property p_hold; clock_hold_n |=> $stable(dq_dev_o) && $stable(dq_dev_oe); endproperty
    a_hold: assert property (p_hold) else $error("blocked edge changed output");
    property p_hold_rd; ld && rw ##1 clock_hold_n [*3] ##1 run [*2] |=> dq_dev_oe; endproperty
    a_hold_rd: assert property (p_hold_rd) else $error("blocked edge counted");
    property p_rst_hiz; $rose(rst_n) |-> !dq_dev_oe; endproperty
    a_rst_hiz: assert property (p_rst_hiz) else $error("bus driven after reset");
    property p_cs_pair;
        chip_select_second == !chip_select_first_n && chip_select_second_n == chip_select_first_n;
    endproperty
    a_cs_pair: assert property (p_cs_pair) else $error("selects not paired");
endmodule

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam pbs_pkg::pbs_data_t BASE = 36'h95A3C0F10;
    logic               clk, rst_n, req_valid, req_ready, req_write, req_burst;
    logic               req_linear, hold, rd_valid;
    pbs_pkg::pbs_addr_t req_addr;
    pbs_pkg::pbs_bw_t   req_bw_n;
    pbs_pkg::pbs_data_t wr_data, rd_data;
    int                 n_mismatch, num_checks;
    pbs_bus_if bus ();
    pbs_sram_dev i_pbs_sram_dev (.clk(clk), .rst_n(rst_n), .bus(bus));
    pbs_sram_host i_pbs_sram_host (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_burst(req_burst),
        .req_linear(req_linear), .hold(hold), .req_addr(req_addr), .req_bw_n(req_bw_n),
        .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid), .bus(bus));
    pbs_bus_assertions i_chk (.clk(clk), .rst_n(rst_n), .clock_hold_n(bus.clock_hold_n),
        .advance_or_load(bus.advance_or_load), .rw(bus.rw),
        .chip_select_first_n(bus.chip_select_first_n),
        .chip_select_second_n(bus.chip_select_second_n),
        .chip_select_second(bus.chip_select_second), .dq_dev_oe(bus.dq_dev_oe),
        .dq_dev_o(bus.dq_dev_o));
    // ------------------------------------------------
    // shared tasks
    // ------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic fail(input string m);
        n_mismatch++;
        $display("CHECK FAILED %0t %s", $time, m);
    endtask
    task automatic issue(input logic w, input logic b, input logic l,
                         input pbs_pkg::pbs_addr_t a, input pbs_pkg::pbs_bw_t bw,
                         input pbs_pkg::pbs_data_t d);
        int i;
        @(negedge clk);
        {req_valid, req_write, req_burst, req_linear} = {1'b1, w, b, l};
        req_addr = a;
        req_bw_n = bw;
        wr_data  = d;
        i = 0;
        while (req_ready !== 1'b1 && i < 50) begin @(negedge clk); i++; end
        if (i == 50) begin fail("request not taken"); give_verdict(); end
        @(negedge clk);
        req_valid = 1'b0;
        for (i = 1; i < 4 && b && w; i++) begin wr_data = d + 36'(i); @(negedge clk); end
    endtask
    task automatic rd_burst(input logic l, input pbs_pkg::pbs_addr_t a, input logic hd,
                            input pbs_pkg::pbs_data_t m3);
        int t;
        logic [1:0] lo;
        issue(1'b0, 1'b1, l, a, 4'hF, '0);
        if (hd) begin hold = 1'b1; repeat (3) @(negedge clk); hold = 1'b0; end
        for (int k = 0; k < 4; k++) begin
            lo = l ? a[1:0] + 2'(k) : a[1:0] ^ 2'(k);
            t = 0;
            do begin @(posedge clk); #1; t++; end while (rd_valid !== 1'b1 && t < 40);
            if (t == 40) begin fail("no read data"); give_verdict(); end
            num_checks++;
            if (rd_data !== ((BASE + 36'(lo)) & (lo == 2'h3 ? m3 : '1))) fail("read data");
        end
    endtask
    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic sc_reset();
        num_checks++;
        if (bus.dq_dev_oe !== 1'b0) fail("bus driven after reset");
    endtask
    task automatic sc_orders();
        issue(1'b1, 1'b1, 1'b1, 17'h00010, 4'h0, BASE);
        rd_burst(1'b0, 17'h00011, 1'b0, '1);
        rd_burst(1'b1, 17'h00012, 1'b0, '1);
    endtask
    task automatic sc_hold_bytes();
        issue(1'b1, 1'b0, 1'b1, 17'h00013, 4'hE, '0);
        rd_burst(1'b1, 17'h00010, 1'b1, 36'hFFFFFFE00);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        {n_mismatch, num_checks} = '0;
        {rst_n, req_valid, req_write, req_burst, hold} = '0;
        req_linear = 1'b1;
        req_addr = '0;
        req_bw_n = '1;
        wr_data = '0;
        repeat (3) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        @(negedge clk);
        sc_reset();
        sc_orders();
        sc_hold_bytes();
        give_verdict();
    end
endmodule
